// *** rtl/npc_pkg.sv ***
// Constants, register map and state type for the nonce and pause command unit
package npc_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_CMD     = 8'h04;
  localparam logic [7:0] OFS_LEN     = 8'h08;
  localparam logic [7:0] OFS_STATUS  = 8'h0c;
  localparam logic [7:0] OFS_CFG     = 8'h10;
  localparam logic [7:0] OFS_HOST    = 8'h20;
  localparam logic [7:0] OFS_SCRATCH = 8'h40;
  localparam logic [7:0] OFS_REPLY   = 8'h60;

  // ==========================================================================
  // Field positions
  localparam int CTRL_GO     = 0;
  localparam int CTRL_WAKE   = 1;
  localparam int CFG_LOCK    = 8;
  localparam int SP_REHASH   = 15;
  localparam int STS_BUSY    = 0;
  localparam int STS_VALID   = 1;
  localparam int STS_ORIGIN  = 2;
  localparam int STS_IDLE    = 3;
  localparam int STS_DONE    = 4;
  localparam int STS_ERR     = 5;
  localparam int STS_RLEN    = 8;
  localparam int HOST_KEEP_W = 160;
  localparam int MSG_W       = 440;

  // ==========================================================================
  // Opcodes, modes, codes
  localparam logic [7:0]   OP_NONCE     = 8'h16;
  localparam logic [7:0]   OP_PAUSE     = 8'h01;
  localparam logic [7:0]   RC_OK        = 8'h00;
  localparam logic [7:0]   RC_ERR       = 8'h0f;
  localparam logic [1:0]   MODE_SEED    = 2'h0;
  localparam logic [1:0]   MODE_KEEP    = 2'h1;
  localparam logic [1:0]   MODE_BAD     = 2'h2;
  localparam logic [1:0]   MODE_PASS    = 2'h3;
  localparam logic         ORG_RAND     = 1'b0;
  localparam logic         ORG_INPUT    = 1'b1;
  localparam logic [5:0]   LEN_NONE     = 6'h00;
  localparam logic [5:0]   LEN_ONE      = 6'h01;
  localparam logic [5:0]   LEN_SHORT    = 6'h14;
  localparam logic [5:0]   LEN_FULL     = 6'h20;
  localparam logic [255:0] TEST_PATTERN = {4{64'hffff0000ffff0000}};
  localparam logic [1:0]   RESP_OKAY    = 2'h0;

  // ==========================================================================
  // Command sequencer states
  typedef enum logic [2:0] {
    S_READY = 3'h1,
    S_RNG   = 3'h2,
    S_HASH  = 3'h4
  } npc_state_e;

endpackage

// *** rtl/npc_axil.sv ***
// AXI4-Lite slave front end producing register write pulses and read fetches
`timescale 1ns/1ps
module npc_axil (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write channels
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output wire logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output wire logic        s_axi_wready,
  output wire logic [1:0]  s_axi_bresp,
  output wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // Read channels
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output wire logic        s_axi_arready,
  output wire logic [31:0] s_axi_rdata,
  output wire logic [1:0]  s_axi_rresp,
  output wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Register side
  output wire logic        reg_wr,
  output wire logic [7:0]  reg_waddr,
  output wire logic [31:0] reg_wdata,
  output wire logic [3:0]  reg_wstrb,
  output wire logic [7:0]  reg_raddr,
  input  wire logic [31:0] reg_rdata
);

  typedef struct packed {
    logic        awready;
    logic        aw_held;
    logic [7:0]  waddr;
    logic        wready;
    logic        w_held;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic        wr;
    logic        arready;
    logic        rd_pend;
    logic [7:0]  raddr;
    logic        rvalid;
    logic [31:0] rdata;
  } npc_axil_s;

  localparam npc_axil_s AXIL_RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};

  npc_axil_s q;
  npc_axil_s next_q;

  // ==========================================================================
  // Channel handshakes
  always_comb begin
    next_q    = q;
    next_q.wr = 1'b0;
    // Address and data are taken in either order, then held until paired
    if (s_axi_awvalid && q.awready) begin
      next_q.waddr   = s_axi_awaddr;
      next_q.aw_held = 1'b1;
      next_q.awready = 1'b0;
    end
    if (s_axi_wvalid && q.wready) begin
      next_q.wdata  = s_axi_wdata;
      next_q.wstrb  = s_axi_wstrb;
      next_q.w_held = 1'b1;
      next_q.wready = 1'b0;
    end
    if (q.aw_held && q.w_held && !q.bvalid) begin
      next_q.wr      = 1'b1;
      next_q.bvalid  = 1'b1;
      next_q.aw_held = 1'b0;
      next_q.w_held  = 1'b0;
    end
    if (q.bvalid && s_axi_bready) begin
      next_q.bvalid  = 1'b0;
      next_q.awready = 1'b1;
      next_q.wready  = 1'b1;
    end
    // Read data is fetched one cycle after the address, so the mux sees a stable index
    if (s_axi_arvalid && q.arready) begin
      next_q.raddr   = s_axi_araddr;
      next_q.rd_pend = 1'b1;
      next_q.arready = 1'b0;
    end
    if (q.rd_pend) begin
      next_q.rdata   = reg_rdata;
      next_q.rvalid  = 1'b1;
      next_q.rd_pend = 1'b0;
    end
    if (q.rvalid && s_axi_rready) begin
      next_q.rvalid  = 1'b0;
      next_q.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= AXIL_RST;
    end else begin
      q <= next_q;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bresp   = npc_pkg::RESP_OKAY;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = npc_pkg::RESP_OKAY;
  assign s_axi_rvalid  = q.rvalid;
  assign reg_wr        = q.wr;
  assign reg_waddr     = q.waddr;
  assign reg_wdata     = q.wdata;
  assign reg_wstrb     = q.wstrb;
  assign reg_raddr     = q.raddr;

endmodule

// *** rtl/npc_nonce_pause.sv ***
// Nonce and pause command unit with scratch digest and AXI4-Lite registers
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module npc_nonce_pause (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // AXI4-Lite write channels
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output wire logic         s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output wire logic         s_axi_wready,
  output wire logic [1:0]   s_axi_bresp,
  output wire logic         s_axi_bvalid,
  input  wire logic         s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output wire logic         s_axi_arready,
  output wire logic [31:0]  s_axi_rdata,
  output wire logic [1:0]   s_axi_rresp,
  output wire logic         s_axi_rvalid,
  input  wire logic         s_axi_rready,
  // Hash engine
  output wire logic         hash_start,
  output wire logic [439:0] hash_msg,
  input  wire logic         hash_done,
  input  wire logic [255:0] hash_digest,
  // Random generator
  output wire logic         rng_req,
  output wire logic         rng_seed_update,
  input  wire logic         rng_ack,
  input  wire logic [255:0] rng_value,
  // Power state
  output wire logic         dev_idle
);

  typedef struct packed {
    npc_pkg::npc_state_e state;
    logic [7:0]          opcode;
    logic [7:0]          first_param;
    logic [15:0]         second_param;
    logic [5:0]          data_len;
    logic [255:0]        host_input_value;
    logic [7:0]          selector;
    logic                cfg_locked;
    logic [255:0]        scratch_digest;
    logic                scratch_valid_flag;
    logic                scratch_origin_flag;
    logic [255:0]        rng_output;
    logic [255:0]        reply_payload;
    logic [5:0]          reply_len;
    logic                done;
    logic                err;
    logic                idle;
    logic                rehash;
    logic                hash_start;
    logic [439:0]        hash_msg;
    logic                rng_req;
    logic                seed_upd;
  } npc_core_s;

  localparam npc_core_s CORE_RST = '{state: npc_pkg::S_READY, default: '0};

  npc_core_s   q;
  npc_core_s   next_q;
  logic        reg_wr;
  logic [7:0]  reg_waddr;
  logic [31:0] reg_wdata;
  logic [3:0]  reg_wstrb;
  logic [7:0]  reg_raddr;
  logic [31:0] reg_rdata;

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic in_region(input logic [7:0] addr, input logic [7:0] base);
    return addr[7:5] == base[7:5];
  endfunction

  // Byte 0 of a 32-byte value sits in the top bits, word 0 holds bytes 0 to 3
  function automatic logic [31:0] word_of(input logic [255:0] v, input logic [2:0] idx);
    return v[255 - 32*int'(idx) -: 32];
  endfunction

  function automatic logic [255:0] put_word(input logic [255:0] v, input logic [2:0] idx,
                                            input logic [31:0] w);
    logic [255:0] r;
    r = v;
    r[255 - 32*int'(idx) -: 32] = w;
    return r;
  endfunction

  function automatic logic [439:0] build_msg(input logic [255:0] lead, input logic [255:0] host,
                                             input logic [7:0] mode, input logic [7:0] p2_low);
    return {lead, host[255 -: npc_pkg::HOST_KEEP_W], npc_pkg::OP_NONCE, mode, p2_low};
  endfunction

  // ==========================================================================
  // Bus front end
  npc_axil u_axil (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .reg_wr        (reg_wr),
    .reg_waddr     (reg_waddr),
    .reg_wdata     (reg_wdata),
    .reg_wstrb     (reg_wstrb),
    .reg_raddr     (reg_raddr),
    .reg_rdata     (reg_rdata)
  );

  // ==========================================================================
  // Command decode
  logic       busy;
  logic       go;
  logic       take;
  logic [1:0] mode;
  logic       rehash_req;
  logic       nonce_legal;
  logic       pause_legal;
  logic       sel_match;
  logic       is_nonce;
  logic       is_pause;

  assign busy       = q.state != npc_pkg::S_READY;
  assign go         = reg_wr && reg_waddr == npc_pkg::OFS_CTRL && reg_wstrb[0]
                      && reg_wdata[npc_pkg::CTRL_GO];
  // Commands arriving while idle are dropped until software wakes the unit
  assign take       = go && !busy && !q.idle;
  assign mode       = q.first_param[1:0];
  assign rehash_req = q.second_param[npc_pkg::SP_REHASH];
  assign is_nonce   = q.opcode == npc_pkg::OP_NONCE;
  assign is_pause   = q.opcode == npc_pkg::OP_PAUSE;
  assign nonce_legal = q.first_param[7:2] == '0 && mode != npc_pkg::MODE_BAD
                       && q.second_param[14:0] == '0
                       && q.data_len == (mode == npc_pkg::MODE_PASS ? npc_pkg::LEN_FULL
                                                                    : npc_pkg::LEN_SHORT)
                       && !(mode != npc_pkg::MODE_PASS && rehash_req
                            && !q.scratch_valid_flag);
  assign pause_legal = q.second_param == '0 && q.data_len == npc_pkg::LEN_NONE;
  assign sel_match   = q.first_param == q.selector;

  // ==========================================================================
  // State update
  always_comb begin
    next_q            = q;
    next_q.hash_start = 1'b0;
    next_q.rng_req    = 1'b0;
    // Operands are frozen while a command runs, so late writes cannot corrupt it
    if (reg_wr) begin
      if (reg_waddr == npc_pkg::OFS_CTRL) begin
        if (reg_wstrb[0] && reg_wdata[npc_pkg::CTRL_WAKE]) begin
          next_q.idle = 1'b0;
        end
      end else if (reg_waddr == npc_pkg::OFS_CMD && !busy) begin
        {next_q.second_param, next_q.first_param, next_q.opcode} =
          merge({q.second_param, q.first_param, q.opcode}, reg_wdata, reg_wstrb);
      end else if (reg_waddr == npc_pkg::OFS_LEN && !busy) begin
        next_q.data_len = 6'(merge({26'h0, q.data_len}, reg_wdata, reg_wstrb));
      end else if (reg_waddr == npc_pkg::OFS_CFG) begin
        {next_q.cfg_locked, next_q.selector} =
          9'(merge({23'h0, q.cfg_locked, q.selector}, reg_wdata, reg_wstrb));
      end else if (in_region(reg_waddr, npc_pkg::OFS_HOST) && !busy) begin
        next_q.host_input_value = put_word(q.host_input_value, reg_waddr[4:2],
          merge(word_of(q.host_input_value, reg_waddr[4:2]), reg_wdata, reg_wstrb));
      end
    end
    case (q.state)
      npc_pkg::S_READY: begin
        if (take) begin
          next_q.done          = 1'b1;
          next_q.err           = 1'b0;
          next_q.rehash        = 1'b0;
          next_q.reply_payload = '0;
          next_q.reply_len     = npc_pkg::LEN_ONE;
          if (is_nonce && !nonce_legal) begin
            next_q.reply_payload[255 -: 8] = npc_pkg::RC_ERR;
            next_q.err                     = 1'b1;
          end else if (is_nonce && mode == npc_pkg::MODE_PASS) begin
            next_q.scratch_digest      = q.host_input_value;
            next_q.scratch_valid_flag  = 1'b1;
            next_q.scratch_origin_flag = npc_pkg::ORG_INPUT;
            next_q.reply_payload[255 -: 8] = npc_pkg::RC_OK;
          end else if (is_nonce) begin
            next_q.done       = 1'b0;
            next_q.hash_start = 1'b1;
            next_q.state      = npc_pkg::S_HASH;
            if (rehash_req) begin
              next_q.rehash   = 1'b1;
              next_q.hash_msg = build_msg(q.scratch_digest, q.host_input_value,
                                          q.first_param, q.second_param[7:0]);
            end else if (!q.cfg_locked) begin
              next_q.rng_output = npc_pkg::TEST_PATTERN;
              next_q.hash_msg   = build_msg(npc_pkg::TEST_PATTERN, q.host_input_value,
                                            q.first_param, q.second_param[7:0]);
            end else begin
              next_q.hash_start = 1'b0;
              next_q.rng_req    = 1'b1;
              next_q.seed_upd   = mode == npc_pkg::MODE_SEED;
              next_q.state      = npc_pkg::S_RNG;
            end
          end else if (is_pause && pause_legal && sel_match) begin
            next_q.reply_payload[255 -: 8] = npc_pkg::RC_OK;
          end else if (is_pause && pause_legal) begin
            // Only the idle state exists here; sleep is out of reach by design
            next_q.idle      = 1'b1;
            next_q.reply_len = npc_pkg::LEN_NONE;
          end else begin
            next_q.reply_payload[255 -: 8] = npc_pkg::RC_ERR;
            next_q.err                     = 1'b1;
          end
        end
      end
      npc_pkg::S_RNG: begin
        if (rng_ack) begin
          next_q.rng_output = rng_value;
          next_q.hash_msg   = build_msg(rng_value, q.host_input_value,
                                        q.first_param, q.second_param[7:0]);
          next_q.hash_start = 1'b1;
          next_q.state      = npc_pkg::S_HASH;
        end
      end
      npc_pkg::S_HASH: begin
        if (hash_done) begin
          next_q.scratch_digest     = hash_digest;
          next_q.scratch_valid_flag = 1'b1;
          if (!q.rehash) begin
            next_q.scratch_origin_flag = npc_pkg::ORG_RAND;
          end
          next_q.reply_payload = q.rehash ? hash_digest : q.rng_output;
          next_q.reply_len     = npc_pkg::LEN_FULL;
          next_q.done          = 1'b1;
          next_q.state         = npc_pkg::S_READY;
        end
      end
      default: begin
        next_q.state = npc_pkg::S_READY;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= CORE_RST;
    end else begin
      q <= next_q;
    end
  end

  // ==========================================================================
  // Register read mux
  always_comb begin
    reg_rdata = '0;
    if (reg_raddr == npc_pkg::OFS_CMD) begin
      reg_rdata = {q.second_param, q.first_param, q.opcode};
    end else if (reg_raddr == npc_pkg::OFS_LEN) begin
      reg_rdata[5:0] = q.data_len;
    end else if (reg_raddr == npc_pkg::OFS_STATUS) begin
      reg_rdata[npc_pkg::STS_BUSY]      = busy;
      reg_rdata[npc_pkg::STS_VALID]     = q.scratch_valid_flag;
      reg_rdata[npc_pkg::STS_ORIGIN]    = q.scratch_origin_flag;
      reg_rdata[npc_pkg::STS_IDLE]      = q.idle;
      reg_rdata[npc_pkg::STS_DONE]      = q.done;
      reg_rdata[npc_pkg::STS_ERR]       = q.err;
      reg_rdata[npc_pkg::STS_RLEN +: 6] = q.reply_len;
    end else if (reg_raddr == npc_pkg::OFS_CFG) begin
      reg_rdata[8:0] = {q.cfg_locked, q.selector};
    end else if (in_region(reg_raddr, npc_pkg::OFS_HOST)) begin
      reg_rdata = word_of(q.host_input_value, reg_raddr[4:2]);
    end else if (in_region(reg_raddr, npc_pkg::OFS_SCRATCH)) begin
      reg_rdata = word_of(q.scratch_digest, reg_raddr[4:2]);
    end else if (in_region(reg_raddr, npc_pkg::OFS_REPLY)) begin
      reg_rdata = word_of(q.reply_payload, reg_raddr[4:2]);
    end
  end

  assign hash_start      = q.hash_start;
  assign hash_msg        = q.hash_msg;
  assign rng_req         = q.rng_req;
  assign rng_seed_update = q.seed_upd;
  assign dev_idle        = q.idle;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_hash_msg_fields: assert property (q.hash_start |->
      q.hash_msg[23:0] == {npc_pkg::OP_NONCE, q.first_param, q.second_param[7:0]})
    else $error("nonce message tail wrong");
  a_rand_flags_set: assert property (q.state == npc_pkg::S_HASH && hash_done && !q.rehash |=>
      q.scratch_valid_flag && q.scratch_origin_flag == npc_pkg::ORG_RAND
      && q.reply_payload == $past(q.rng_output))
    else $error("random nonce flags or reply wrong");
  a_seed_mode: assert property (take && is_nonce && nonce_legal && !rehash_req
      && q.cfg_locked && mode != npc_pkg::MODE_PASS |=>
      q.rng_req && q.seed_upd == ($past(mode) == npc_pkg::MODE_SEED) ##1 !q.rng_req)
    else $error("seed update request wrong");
  a_rehash_origin: assert property (q.state == npc_pkg::S_HASH && hash_done && q.rehash |=>
      $stable(q.scratch_origin_flag) && q.reply_payload == $past(hash_digest)
      && q.reply_len == npc_pkg::LEN_FULL)
    else $error("re-hash changed origin or reply");
  a_rehash_guard: assert property (take && is_nonce && rehash_req && !q.scratch_valid_flag
      && mode != npc_pkg::MODE_PASS |=> q.err && q.state == npc_pkg::S_READY)
    else $error("re-hash ran without valid scratch");
  a_pass_copy: assert property (take && is_nonce && nonce_legal
      && mode == npc_pkg::MODE_PASS |=> q.scratch_digest == $past(q.host_input_value)
      && q.scratch_origin_flag == npc_pkg::ORG_INPUT && q.reply_len == npc_pkg::LEN_ONE
      && q.reply_payload == '0)
    else $error("pass-through load wrong");
  a_test_pattern: assert property (take && is_nonce && nonce_legal && !rehash_req
      && !q.cfg_locked && mode != npc_pkg::MODE_PASS |=>
      q.hash_start && q.hash_msg[439 -: 256] == npc_pkg::TEST_PATTERN)
    else $error("test pattern not used");
  a_mismatch_idle: assert property (take && is_pause && pause_legal && !sel_match |=>
      q.idle && q.reply_len == npc_pkg::LEN_NONE && !q.hash_start && !q.rng_req)
    else $error("selector mismatch did not idle");
  a_match_reply: assert property (take && is_pause && pause_legal && sel_match |=>
      !q.idle && q.reply_len == npc_pkg::LEN_ONE && q.reply_payload == '0)
    else $error("selector match reply wrong");
  a_reject_keeps: assert property (take && is_nonce && !nonce_legal |=>
      $stable(q.scratch_digest) && q.err && q.reply_payload[255 -: 8] == npc_pkg::RC_ERR)
    else $error("illegal nonce changed scratch");

endmodule

// *** tb/npc_far_model.sv ***
// Hash engine and random generator model for the command unit
`timescale 1ns/1ps
module npc_far_model #(
  parameter int DLY = 4
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Requests from the unit
  input  wire logic         hash_start,
  input  wire logic [439:0] hash_msg,
  input  wire logic         rng_req,
  input  wire logic         rng_seed_update,
  // Answers
  output logic              hash_done,
  output logic [255:0]      hash_digest,
  output logic              rng_ack,
  output logic [255:0]      rng_value,
  output logic              last_seed
);
  // ==========================================================================
  // Toy digest; inverse shown outside the pulse so stale reads show up
  localparam logic [255:0] RFIX = {8{32'h3c5a96e1}};
  logic [439:0] msg;
  int           hc;
  int           rc;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hc <= 0;
      rc <= 0;
      hash_done <= 1'b0;
      rng_ack <= 1'b0;
      last_seed <= 1'b0;
    end else begin
      hash_done <= (hc == 1);
      rng_ack <= (rc == 1);
      hc <= hash_start ? DLY : hc - int'(hc > 0);
      rc <= rng_req ? DLY : rc - int'(rc > 0);
      if (hash_start) msg <= hash_msg;
      if (rng_req) last_seed <= rng_seed_update;
    end
  end
  assign hash_digest = {256{~hash_done}} ^ ~msg[439:184] ^ {msg[183:0], 72'h0};
  assign rng_value = rng_ack ? RFIX : ~RFIX;
endmodule

// *** tb/testbench.sv ***
// Register-level tests of the nonce and pause command unit
`timescale 1ns/1ps
module testbench;
  // ==========================================================================
  // Stimulus and wiring
  localparam logic [255:0] H = {8{32'h13579bdf}} ^ 256'h0123456789abcdef;
  localparam logic [255:0] RF = {8{32'h3c5a96e1}};
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, arv = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdt, v;
  logic awr, wr, bv, arr, rv, hs, hd, rq, sd, ra, di, ls;
  logic [439:0] hm;
  logic [255:0] hg, rvl, s;
  int fails = 0, check_count = 0;
  logic [31:0] bad [4] = '{32'h216, 32'h416, 32'h10016, 32'h316};
  npc_nonce_pause dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(), .s_axi_bvalid(bv),
    .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdt), .s_axi_rresp(), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
    .hash_start(hs), .hash_msg(hm), .hash_done(hd), .hash_digest(hg), .rng_req(rq),
    .rng_seed_update(sd), .rng_ack(ra), .rng_value(rvl), .dev_idle(di));
  npc_far_model far_u (.aclk(aclk), .aresetn(aresetn), .hash_start(hs), .hash_msg(hm),
    .rng_req(rq), .rng_seed_update(sd), .hash_done(hd), .hash_digest(hg),
    .rng_ack(ra), .rng_value(rvl), .last_seed(ls));
  always #5 aclk = ~aclk;
  // ==========================================================================
  // Bus tasks and checks
  task automatic wrt(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1;
    pw = 1;
    awa <= a; wd <= d; awv <= 1; wv <= 1;
    do begin
      @(posedge aclk);
      if (awr && pa) begin awv <= 0; pa = 0; end
      if (wr && pw) begin wv <= 0; pw = 0; end
    end while (!(bv && !pa && !pw));
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    ara <= a; arv <= 1;
    do begin @(posedge aclk); if (arr) arv <= 0; end while (!rv);
    d = rdt;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin fails++; $display("[ERR] %0t got %h exp %h", $time, g, e); end
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    rd(a, v); cmp(v, e);
  endtask
  task automatic chk8(input logic [7:0] a, input logic [255:0] e);
    for (int i = 0; i < 8; i++) chk(a + 8'(4 * i), e[255 - 32 * i -: 32]);
  endtask
  task automatic run(input logic [31:0] c, input logic [5:0] lx = 6'h0);
    wrt(npc_pkg::OFS_CMD, c);
    wrt(npc_pkg::OFS_LEN, {26'h0, lx ^ ((c[7:0] == 8'h01) ? 6'h0
                                      : (c[9:8] == 2'h3) ? 6'h20 : 6'h14)});
    wrt(npc_pkg::OFS_CTRL, 32'h1);
    // A hang here is left to the watchdog
    do rd(npc_pkg::OFS_STATUS, v); while (!(v[4] && !v[0]));
  endtask
  function automatic logic [255:0] f(input logic [255:0] l, input logic [7:0] m,
                                     input logic [255:0] h = H);
    return ~l ^ {h[255:96], 8'h16, m, 8'h00, 72'h0};
  endfunction
  task automatic complete_run;
    if (fails == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin #400000; fails++; complete_run; end
  // ==========================================================================
  // Tests
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    chk(npc_pkg::OFS_STATUS, 32'h0);
    run(32'h80000016);
    chk(npc_pkg::OFS_STATUS, 32'h130);
    for (int i = 0; i < 8; i++) wrt(npc_pkg::OFS_HOST + 8'(4 * i), H[255 - 32 * i -: 32]);
    run(32'h16);
    chk(npc_pkg::OFS_STATUS, 32'h2012);
    chk8(npc_pkg::OFS_SCRATCH, f(npc_pkg::TEST_PATTERN, 8'h0));
    chk8(npc_pkg::OFS_REPLY, npc_pkg::TEST_PATTERN);
    run(32'h316);
    chk(npc_pkg::OFS_STATUS, 32'h116);
    chk8(npc_pkg::OFS_SCRATCH, H);
    chk(npc_pkg::OFS_REPLY, 32'h0);
    run(32'h80000116);
    s = f(H, 8'h1);
    chk(npc_pkg::OFS_STATUS, 32'h2016);
    chk8(npc_pkg::OFS_SCRATCH, s);
    chk8(npc_pkg::OFS_REPLY, s);
    for (int i = 0; i < 4; i++) begin
      run(bad[i], 6'(i == 3));
      chk(npc_pkg::OFS_STATUS, 32'h136);
      chk(npc_pkg::OFS_REPLY, 32'h0f000000);
      chk8(npc_pkg::OFS_SCRATCH, s);
    end
    wrt(npc_pkg::OFS_CFG, 32'h15a);
    for (int m = 0; m < 2; m++) begin
      wrt(npc_pkg::OFS_HOST, H[255 -: 32] ^ 32'(m + 1));
      run({16'h0, 8'(m), 8'h16});
      cmp({31'h0, ls}, 32'(1 - m));
      chk8(npc_pkg::OFS_SCRATCH, f(RF, 8'(m), H ^ {32'(m + 1), 224'h0}));
      chk8(npc_pkg::OFS_REPLY, RF);
    end
    run(32'h5a01);
    chk(npc_pkg::OFS_STATUS, 32'h112);
    chk(npc_pkg::OFS_REPLY, 32'h0);
    run(32'h3301);
    cmp({31'h0, di}, 32'h1);
    chk(npc_pkg::OFS_STATUS, 32'h1a);
    wrt(npc_pkg::OFS_CTRL, 32'h2);
    chk(npc_pkg::OFS_STATUS, 32'h12);
    wrt(8'hfc, 32'hffffffff);
    chk(8'hfc, 32'h0);
    complete_run;
  end
endmodule
